// ### serial_rx_pkg.sv
// shared constants and types of the serial receive status block
package serial_rx_pkg;

    // ------------------------------------------------------------
    // oversampling and receiver timing
    // ------------------------------------------------------------
    localparam int OVS = 16;
    localparam logic [3:0] OS_FIRST = 4'h1;
    localparam logic [3:0] SAMPLE_A = 4'h7;
    localparam logic [3:0] SAMPLE_B = 4'h8;
    localparam logic [3:0] SAMPLE_C = 4'h9;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int IDLE_BITS = 10;
    localparam logic [7:0] IDLE_TICKS = 8'(IDLE_BITS * OVS);

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_BAUD = 8'h0C;
    localparam logic [7:0] OFS_ISTAT = 8'h10;
    localparam logic [7:0] OFS_IMASK = 8'h14;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int FLAG_W = 6;
    localparam int ST_PERR = 0;
    localparam int ST_FERR = 1;
    localparam int ST_NOISE = 2;
    localparam int ST_OVR = 3;
    localparam int ST_IDLE = 4;
    localparam int ST_FULL = 5;
    localparam int CTRL_W = 3;
    localparam int CT_PCE = 0;
    localparam int CT_ODD = 1;
    localparam int CT_WAKE = 2;
    localparam int BAUD_W = 16;
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    localparam logic [BAUD_W-1:0] BAUD_RST = 16'h0035;
    localparam logic [FLAG_W-1:0] MASK_RST = 6'h00;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PAR = 3'b011,
        RX_STOP = 3'b100
    } rx_state_e;

    typedef struct packed {
        logic parity_check_enable;
        logic parity_odd_select;
    } rx_cfg_s;

    typedef struct packed {
        logic [7:0] data;
        logic noise;
        logic frame_err;
        logic parity_err;
    } rx_frame_s;

endpackage

// ### serial_rx_frame.sv
// oversampling frame receiver: start, data, parity and stop with noise vote
`timescale 1ns/1ps
module serial_rx_frame (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // line and control
    input wire logic rxd,
    input wire logic hold,
    input serial_rx_pkg::rx_cfg_s cfg,
    input wire logic [serial_rx_pkg::BAUD_W-1:0] div,
    // results
    output logic done,
    output serial_rx_pkg::rx_frame_s frame,
    output logic idle_pulse
);
    logic rxd_m, rxd_s;
    logic [serial_rx_pkg::BAUD_W-1:0] div_cnt;
    logic tick;
    serial_rx_pkg::rx_state_e state;
    logic [3:0] os_cnt;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic s_a, s_b, par_bit, noisy;
    logic bit_val, bit_noisy, decide;
    logic [7:0] idle_cnt;
    logic idle_armed;

    // two-flop synchroniser, only rxd_s is read by logic
    always_ff @(posedge clk) begin
        rxd_m <= rst_n ? rxd : 1'b1;
        rxd_s <= rst_n ? rxd_m : 1'b1;
    end

    // oversample enable, period is div+1 clocks
    assign tick = (div_cnt == '0);
    always_ff @(posedge clk) begin
        if (!rst_n || tick) begin
            div_cnt <= rst_n ? div : '0;
        end else begin
            div_cnt <= div_cnt - 1'b1;
        end
    end

    // three samples around bit centre, majority wins
    assign decide = tick && (state != serial_rx_pkg::RX_IDLE) && (os_cnt == serial_rx_pkg::SAMPLE_C);
    assign bit_val = (s_a & s_b) | (s_a & rxd_s) | (s_b & rxd_s);
    assign bit_noisy = !((s_a == s_b) && (s_b == rxd_s));
    always_ff @(posedge clk) begin
        if (tick && os_cnt == serial_rx_pkg::SAMPLE_A) begin
            s_a <= rxd_s;
        end
        if (tick && os_cnt == serial_rx_pkg::SAMPLE_B) begin
            s_b <= rxd_s;
        end
    end

    // frame sequencer; a held receiver ignores start edges
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= serial_rx_pkg::RX_IDLE;
            os_cnt <= '0;
            bit_cnt <= '0;
            noisy <= 1'b0;
        end else if (tick) begin
            case (state)
                serial_rx_pkg::RX_IDLE: begin
                    if (!rxd_s && !hold) begin
                        state <= serial_rx_pkg::RX_START;
                        os_cnt <= serial_rx_pkg::OS_FIRST;
                        noisy <= 1'b0;
                    end
                end
                default: begin
                    os_cnt <= os_cnt + 1'b1;
                    if (decide) begin
                        noisy <= noisy | bit_noisy;
                        case (state)
                            serial_rx_pkg::RX_START: begin
                                state <= bit_val ? serial_rx_pkg::RX_IDLE : serial_rx_pkg::RX_DATA;
                                bit_cnt <= '0;
                            end
                            serial_rx_pkg::RX_DATA: begin
                                bit_cnt <= bit_cnt + 1'b1;
                                if (bit_cnt == serial_rx_pkg::LAST_BIT) begin
                                    state <= cfg.parity_check_enable ?
                                        serial_rx_pkg::RX_PAR : serial_rx_pkg::RX_STOP;
                                end
                            end
                            serial_rx_pkg::RX_PAR: begin
                                state <= serial_rx_pkg::RX_STOP;
                            end
                            default: begin
                                state <= serial_rx_pkg::RX_IDLE;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // data and parity bit capture
    always_ff @(posedge clk) begin
        if (decide && state == serial_rx_pkg::RX_DATA) begin
            shift <= {bit_val, shift[7:1]};
        end
        if (decide && state == serial_rx_pkg::RX_PAR) begin
            par_bit <= bit_val;
        end
    end

    // finished frame, reported at the stop bit centre
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done <= 1'b0;
            frame <= '0;
        end else begin
            done <= decide && (state == serial_rx_pkg::RX_STOP);
            if (decide && state == serial_rx_pkg::RX_STOP) begin
                frame.data <= shift;
                frame.noise <= noisy | bit_noisy;
                frame.frame_err <= !bit_val;
                frame.parity_err <= cfg.parity_check_enable &&
                    ((^shift ^ par_bit) != cfg.parity_odd_select);
            end
        end
    end

    // idle line: ten bit times of mark after a frame, reported once
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idle_cnt <= '0;
            idle_armed <= 1'b0;
            idle_pulse <= 1'b0;
        end else begin
            idle_pulse <= 1'b0;
            if (state != serial_rx_pkg::RX_IDLE || !rxd_s) begin
                idle_cnt <= '0;
                idle_armed <= 1'b1;
            end else if (tick && idle_armed) begin
                idle_cnt <= idle_cnt + 1'b1;
                if (idle_cnt == serial_rx_pkg::IDLE_TICKS - 8'h01) begin
                    idle_pulse <= 1'b1;
                    idle_armed <= 1'b0;
                end
            end
        end
    end
endmodule

// ### serial_rx_error_flags.sv
// receive status flags of an asynchronous serial port with an apb register slave
//
// Summary of operation
// - overrun bit 3 sets when a frame completes while the previous one is unread
// - on overrun the new frame is dropped, held receive data stays unchanged
// - overrun clears only by status read with it set, then a data read
// - noise bit 2 sets together with receive-full, never on an overrun frame
// - noise clears by a status read followed by a data read
// - framing error bit 1 sets on a zero stop bit, with receive-full, not on overrun
// - while framing error is set no new frame is accepted
// - framing error clears by a status read that saw it, then a data read
// - parity error bit 0 sets on parity mismatch when checking is on, with receive-full
// - parity error clears by a status read followed by a data read
// - while receiver wakeup is set the idle flag is not raised
// - overrun seen after the arming status read survives a data read; needs another pair
// - each error flag reads one when detected, zero otherwise
`timescale 1ns/1ps
module serial_rx_error_flags (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RSTN,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // serial line
    input wire logic RXD,
    // interrupt
    output logic IRQ
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [serial_rx_pkg::CTRL_W-1:0] ctrl_r;
    logic [serial_rx_pkg::BAUD_W-1:0] baud_r;
    logic [7:0] data_r;
    logic [serial_rx_pkg::FLAG_W-1:0] flag_r;
    logic [serial_rx_pkg::FLAG_W-1:0] armed_r;
    logic [serial_rx_pkg::FLAG_W-1:0] irq_stat_r;
    logic [serial_rx_pkg::FLAG_W-1:0] irq_mask_r;
    logic [serial_rx_pkg::FLAG_W-1:0] set_vec;
    logic [serial_rx_pkg::FLAG_W-1:0] clr_vec;
    logic [31:0] rd_word;
    logic rd_hit;
    logic access, rd_stat, rd_data, rd_istat;
    logic fr_done, idle_pulse, load, ovr_evt;
    serial_rx_pkg::rx_frame_s fr;
    serial_rx_pkg::rx_cfg_s cfg;

    function automatic logic sel(input logic [7:0] addr, input logic [7:0] ofs);
        sel = (addr == ofs);
    endfunction

    // ------------------------------------------------------------
    // frame receiver
    // ------------------------------------------------------------
    assign cfg.parity_check_enable = ctrl_r[serial_rx_pkg::CT_PCE];
    assign cfg.parity_odd_select = ctrl_r[serial_rx_pkg::CT_ODD];

    // the framing set pulse holds too: the low stop bit would look like a start
    serial_rx_frame u_rx (
        .clk(CLOCK),
        .rst_n(RSTN),
        .rxd(RXD),
        .hold(flag_r[serial_rx_pkg::ST_FERR] || set_vec[serial_rx_pkg::ST_FERR]),
        .cfg(cfg),
        .div(baud_r),
        .done(fr_done),
        .frame(fr),
        .idle_pulse(idle_pulse)
    );

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    // pready is raised for the access cycle, so every transfer takes two cycles
    assign access = PSEL && PENABLE && PREADY;
    assign rd_stat = access && !PWRITE && sel(PADDR, serial_rx_pkg::OFS_STATUS);
    assign rd_data = access && !PWRITE && sel(PADDR, serial_rx_pkg::OFS_DATA);
    assign rd_istat = access && !PWRITE && sel(PADDR, serial_rx_pkg::OFS_ISTAT);

    // read multiplexer; reserved bits read zero
    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        if (sel(PADDR, serial_rx_pkg::OFS_STATUS)) begin
            rd_word[serial_rx_pkg::FLAG_W-1:0] = flag_r;
        end else if (sel(PADDR, serial_rx_pkg::OFS_DATA)) begin
            rd_word[7:0] = data_r;
        end else if (sel(PADDR, serial_rx_pkg::OFS_CTRL)) begin
            rd_word[serial_rx_pkg::CTRL_W-1:0] = ctrl_r;
        end else if (sel(PADDR, serial_rx_pkg::OFS_BAUD)) begin
            rd_word[serial_rx_pkg::BAUD_W-1:0] = baud_r;
        end else if (sel(PADDR, serial_rx_pkg::OFS_ISTAT)) begin
            rd_word[serial_rx_pkg::FLAG_W-1:0] = irq_stat_r;
        end else if (sel(PADDR, serial_rx_pkg::OFS_IMASK)) begin
            rd_word[serial_rx_pkg::FLAG_W-1:0] = irq_mask_r;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // answer registered in the setup cycle, held through the access cycle
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            PREADY <= 1'b0;
            PRDATA <= '0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            if (PSEL && !PENABLE) begin
                PRDATA <= PWRITE ? 32'h0000_0000 : rd_word;
                PSLVERR <= !rd_hit;
            end
        end
    end

    // writable control registers; writes to read-only words are dropped
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            ctrl_r <= serial_rx_pkg::CTRL_RST;
            baud_r <= serial_rx_pkg::BAUD_RST;
            irq_mask_r <= serial_rx_pkg::MASK_RST;
        end else if (access && PWRITE) begin
            if (sel(PADDR, serial_rx_pkg::OFS_CTRL)) begin
                ctrl_r <= PWDATA[serial_rx_pkg::CTRL_W-1:0];
            end else if (sel(PADDR, serial_rx_pkg::OFS_BAUD)) begin
                baud_r <= PWDATA[serial_rx_pkg::BAUD_W-1:0];
            end else if (sel(PADDR, serial_rx_pkg::OFS_IMASK)) begin
                irq_mask_r <= PWDATA[serial_rx_pkg::FLAG_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // receive flags
    // ------------------------------------------------------------
    // a frame finishing while data is unread is an overrun, even in the
    // very cycle the data read clears full: the old byte was not yet gone
    assign ovr_evt = fr_done && flag_r[serial_rx_pkg::ST_FULL];
    assign load = fr_done && !flag_r[serial_rx_pkg::ST_FULL];

    // noise, framing and parity flags only ever set on a loaded frame, never on an overrun
    always_comb begin
        set_vec = '0;
        set_vec[serial_rx_pkg::ST_FULL] = load;
        set_vec[serial_rx_pkg::ST_OVR] = ovr_evt;
        set_vec[serial_rx_pkg::ST_NOISE] = load && fr.noise;
        set_vec[serial_rx_pkg::ST_FERR] = load && fr.frame_err;
        set_vec[serial_rx_pkg::ST_PERR] = load && fr.parity_err;
        set_vec[serial_rx_pkg::ST_IDLE] = idle_pulse && !ctrl_r[serial_rx_pkg::CT_WAKE];
    end

    // only flags that the status read returned as set are cleared by the data read
    assign clr_vec = rd_data ? armed_r : '0;

    // snapshot of the status word software actually received
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            armed_r <= '0;
        end else if (rd_stat) begin
            armed_r <= PRDATA[serial_rx_pkg::FLAG_W-1:0];
        end else if (rd_data) begin
            armed_r <= '0;
        end
    end

    // flags: set wins over a clear in the same cycle
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            flag_r <= '0;
        end else begin
            flag_r <= (flag_r & ~clr_vec) | set_vec;
        end
    end

    // held data changes only on a frame that did not overrun
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            data_r <= '0;
        end else if (load) begin
            data_r <= fr.data;
        end
    end

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    // sticky event bits, cleared by reading them; a new event survives the read
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (rd_istat ? '0 : irq_stat_r) | set_vec;
        end
    end

    // one cycle behind the status bits, kept registered for a clean output
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    a_overrun_sets_flag: assert property (ovr_evt |=> flag_r[serial_rx_pkg::ST_OVR])
        else $error("overrun not flagged");
    a_overrun_keeps_data: assert property (ovr_evt |=> $stable(data_r) &&
        (flag_r[serial_rx_pkg::ST_FULL] || $past(rd_data)))
        else $error("overrun altered held data");
    a_overrun_clear_pair: assert property ($fell(flag_r[serial_rx_pkg::ST_OVR]) |->
        $past(rd_data) && $past(armed_r[serial_rx_pkg::ST_OVR]))
        else $error("overrun cleared without status and data reads");
    a_noise_with_full: assert property ($rose(flag_r[serial_rx_pkg::ST_NOISE]) |->
        $rose(flag_r[serial_rx_pkg::ST_FULL]))
        else $error("noise set apart from receive full");
    a_noise_clear_pair: assert property ($fell(flag_r[serial_rx_pkg::ST_NOISE]) |->
        $past(rd_data) && $past(armed_r[serial_rx_pkg::ST_NOISE]))
        else $error("noise cleared without read pair");
    a_framing_with_full: assert property ($rose(flag_r[serial_rx_pkg::ST_FERR]) |->
        $rose(flag_r[serial_rx_pkg::ST_FULL]) && $past(fr.frame_err))
        else $error("framing error set apart from receive full");
    a_framing_blocks_rx: assert property (flag_r[serial_rx_pkg::ST_FERR] [*2] |->
        !fr_done)
        else $error("frame accepted while framing error set");
    a_framing_clear_pair: assert property ($fell(flag_r[serial_rx_pkg::ST_FERR]) |->
        $past(rd_data) && $past(armed_r[serial_rx_pkg::ST_FERR]))
        else $error("framing error cleared without read pair");
    a_parity_with_full: assert property ($rose(flag_r[serial_rx_pkg::ST_PERR]) |->
        $rose(flag_r[serial_rx_pkg::ST_FULL]) && $past(ctrl_r[serial_rx_pkg::CT_PCE]))
        else $error("parity error set apart from receive full");
    a_parity_clear_pair: assert property ($fell(flag_r[serial_rx_pkg::ST_PERR]) |->
        $past(rd_data) && $past(armed_r[serial_rx_pkg::ST_PERR]))
        else $error("parity error cleared without read pair");
    a_wakeup_blocks_idle: assert property ((ctrl_r[serial_rx_pkg::CT_WAKE] &&
        !flag_r[serial_rx_pkg::ST_IDLE]) |=> !flag_r[serial_rx_pkg::ST_IDLE])
        else $error("idle flag raised under wakeup");
    a_overrun_survives: assert property ((flag_r[serial_rx_pkg::ST_OVR] &&
        !(rd_data && armed_r[serial_rx_pkg::ST_OVR])) |=> flag_r[serial_rx_pkg::ST_OVR])
        else $error("overrun dropped without armed data read");
    a_status_reads_flags: assert property (rd_stat |->
        PRDATA[serial_rx_pkg::FLAG_W-1:0] == $past(flag_r))
        else $error("status read does not show flags");

    c_overrun: cover property (ovr_evt ##[1:1000] rd_data);
    c_framing: cover property ($rose(flag_r[serial_rx_pkg::ST_FERR]));
    c_idle: cover property ($rose(flag_r[serial_rx_pkg::ST_IDLE]));
    c_irq: cover property ($rose(IRQ));
endmodule

// ### serial_tx_model.sv
// behavioural remote transmitter that drives the receive line
`timescale 1ns/1ps
module serial_tx_model (
    // clock
    input wire logic clk,
    // serial line
    output logic rxd
);
    // ------------------------------------------------------------
    // frame sender
    // ------------------------------------------------------------
    localparam int BIT_CLKS = 16; // one bit with the divider at zero

    initial rxd = 1'b1;

    // start, 8 data bits lsb first, optional parity, stop; the two glitches
    // sit three clocks apart so at most one of the three vote samples flips
    task automatic send(input logic [7:0] d, input logic pen, input logic pbit,
                        input logic stop, input logic glitch);
        logic [10:0] bits;
        int n;
        bits = {stop, pbit, d, 1'b0};
        n = pen ? 11 : 10;
        if (!pen) begin
            bits[9] = stop;
        end
        for (int i = 0; i < n; i++) begin
            for (int c = 0; c < BIT_CLKS; c++) begin
                @(posedge clk);
                rxd <= (glitch && i == 1 && (c == 9 || c == 12)) ? ~bits[i] : bits[i];
            end
        end
        @(posedge clk);
        rxd <= 1'b1; // mark between frames
    endtask
endmodule

// ### serial_rx_error_flags_test.sv
// self-checking bench for the receive status flags block
`timescale 1ns/1ps
module serial_rx_error_flags_test;
    // ------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------
    logic CLOCK = 1'b0;
    logic RSTN = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h00000000;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic RXD;
    logic IRQ;
    int mismatches = 0;
    int n_checks = 0;
    integer seed = 32'h788996E8;
    logic [40:0] notes[$]; // address, error bit and data of reads in flight
    logic [40:0] note;
    logic [7:0] d;
    logic [7:0] e;

    always #5 CLOCK = ~CLOCK;

    serial_rx_error_flags i_dut (.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .RXD(RXD), .IRQ(IRQ));
    serial_tx_model i_tx (.clk(CLOCK), .rxd(RXD));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until pready is sampled high, released only after that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLOCK);
        end while (PREADY !== 1'b1);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        notes.push_back({a, exp});
        apb(1'b0, a, 32'h00000000);
    endtask

    task automatic st(input logic [5:0] v);
        rd(serial_rx_pkg::OFS_STATUS, {27'h0000000, v});
    endtask

    task automatic dat(input logic [7:0] v);
        rd(serial_rx_pkg::OFS_DATA, {25'h0000000, v});
    endtask

    task automatic frame(input logic [7:0] v, input logic pen, input logic pb,
                         input logic stop, input logic gl);
        i_tx.send(v, pen, pb, stop, gl);
        repeat (6) @(posedge CLOCK);
    endtask

    task automatic conclude();
        check("reads left unanswered", {1'b0, 32'(notes.size())}, 33'h000000000);
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // result watcher: each completed read is matched to the oldest note
    // ------------------------------------------------------------
    always @(posedge CLOCK) begin
        if (PSEL === 1'b1 && PENABLE === 1'b0) begin
            check("ready in setup", {32'h00000000, PREADY}, 33'h000000000);
        end
        if (PSEL && PENABLE && PREADY === 1'b1 && PWRITE === 1'b0) begin
            note = notes.pop_front();
            check($sformatf("read %h", note[40:33]), {PSLVERR, PRDATA}, note[32:0]);
        end
    end

    // hang guard, far above the few thousand cycles the sequence needs
    initial begin
        repeat (20000) @(posedge CLOCK);
        mismatches++;
        conclude();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge CLOCK);
        RSTN <= 1'b1;
        rd(serial_rx_pkg::OFS_CTRL, 33'h000000000);
        rd(serial_rx_pkg::OFS_BAUD, 33'h000000035);
        rd(serial_rx_pkg::OFS_IMASK, 33'h000000000);
        st(6'h00);
        rd(8'h18, 33'h100000000);
        apb(1'b1, serial_rx_pkg::OFS_STATUS, 32'h000000FF);
        st(6'h00);
        apb(1'b1, serial_rx_pkg::OFS_BAUD, 32'h00000000);
        apb(1'b1, serial_rx_pkg::OFS_IMASK, 32'h0000003F);
        // the divider ends its count at the reset rate before the new rate holds
        repeat (serial_rx_pkg::BAUD_RST + 16'h0002) @(posedge CLOCK);
        $display("test reset and map: done");
        // idle flag raised without wakeup, interrupt raised then cleared
        d = 8'($random(seed));
        frame(d, 1'b0, 1'b0, 1'b1, 1'b0);
        repeat (200) @(posedge CLOCK);
        check("irq raised", {32'h00000000, IRQ}, 33'h000000001);
        st(6'h30);
        rd(serial_rx_pkg::OFS_ISTAT, 33'h000000030);
        rd(serial_rx_pkg::OFS_ISTAT, 33'h000000000);
        repeat (3) @(posedge CLOCK);
        check("irq cleared", {32'h00000000, IRQ}, 33'h000000000);
        dat(d);
        st(6'h00);
        $display("test idle and interrupt: done");
        // wakeup hides idle; masked events keep the interrupt low
        apb(1'b1, serial_rx_pkg::OFS_CTRL, 32'h00000004);
        apb(1'b1, serial_rx_pkg::OFS_IMASK, 32'h00000000);
        d = 8'($random(seed));
        frame(d, 1'b0, 1'b0, 1'b1, 1'b0);
        repeat (200) @(posedge CLOCK);
        st(6'h20);
        check("irq masked", {32'h00000000, IRQ}, 33'h000000000);
        rd(serial_rx_pkg::OFS_ISTAT, 33'h000000020);
        dat(d);
        st(6'h00);
        apb(1'b1, serial_rx_pkg::OFS_IMASK, 32'h0000003F);
        $display("test wakeup and mask: done");
        // overrun by a noisy second frame: no noise flag, old data kept
        d = 8'($random(seed));
        e = 8'($random(seed));
        frame(d, 1'b0, 1'b0, 1'b1, 1'b0);
        frame(e, 1'b0, 1'b0, 1'b1, 1'b1);
        st(6'h28);
        dat(d);
        st(6'h00);
        // a data read before any status read clears nothing
        frame(e, 1'b0, 1'b0, 1'b1, 1'b0);
        frame(d, 1'b0, 1'b0, 1'b1, 1'b0);
        dat(e);
        st(6'h28);
        dat(e);
        st(6'h00);
        $display("test overrun: done");
        // overrun after the arming read survives and needs a second pair
        frame(d, 1'b0, 1'b0, 1'b1, 1'b0);
        st(6'h20);
        frame(e, 1'b0, 1'b0, 1'b1, 1'b0);
        dat(d);
        st(6'h08);
        dat(d);
        st(6'h00);
        frame(e, 1'b0, 1'b0, 1'b1, 1'b0);
        st(6'h20);
        dat(e);
        $display("test late overrun: done");
        // parity even and odd, good and bad
        for (int m = 0; m < 4; m++) begin
            d = 8'($random(seed));
            apb(1'b1, serial_rx_pkg::OFS_CTRL, {29'h00000000, 1'b1, m[0], 1'b1});
            frame(d, 1'b1, ^d ^ m[0] ^ m[1], 1'b1, 1'b0);
            st({1'b1, 4'h0, m[1]});
            dat(d);
            st(6'h00);
        end
        apb(1'b1, serial_rx_pkg::OFS_CTRL, 32'h00000004);
        $display("test parity: done");
        // noise on a clean-voting bit
        d = 8'($random(seed));
        frame(d, 1'b0, 1'b0, 1'b1, 1'b1);
        st(6'h24);
        dat(d);
        st(6'h00);
        $display("test noise: done");
        // framing error blocks the next frame until cleared
        d = 8'($random(seed));
        e = 8'($random(seed));
        frame(d, 1'b0, 1'b0, 1'b0, 1'b0);
        frame(e, 1'b0, 1'b0, 1'b1, 1'b0);
        st(6'h22);
        dat(d);
        st(6'h00);
        frame(e, 1'b0, 1'b0, 1'b1, 1'b0);
        st(6'h20);
        dat(e);
        $display("test framing: done");
        repeat (2) @(posedge CLOCK);
        conclude();
    end
endmodule
